// >>> common/lia_pkg.sv
// Purpose: Shared constants and types for the line interface interrupt aggregator
// Assumes: 25 MHz device clock, 8-bit register data, 16 channels
// Notes:   Per-channel address = register base + channel code in the low five bits
package lia_pkg;
    // Geometry
    localparam int          NCH          = 16;         // Channels
    localparam int          AW           = 11;         // Register address width
    localparam int          DW           = 8;          // Register data width
    // Timing
    localparam longint      CLK_HZ       = 25000000;   // Device clock rate
    localparam int          CLK_PER_NS   = 40;         // Device clock period
    localparam int          SEC_TIME_S   = 1;          // Timer interval in seconds
    localparam logic [24:0] SEC_CYC      = 25'(CLK_HZ * SEC_TIME_S);
    localparam int          RST_TIME_NS  = 1000;       // Longest soft reset time
    localparam logic [4:0]  RST_CYC      = 5'(RST_TIME_NS / CLK_PER_NS);
    // Global register offsets
    localparam logic [10:0] A_GRST       = 11'h040;    // Global soft reset
    localparam logic [10:0] A_GCR        = 11'h080;    // global_config_reg
    localparam logic [10:0] A_SUMM1      = 11'h2c0;    // channel_summary_regs, channels 1..8
    localparam logic [10:0] A_SUMM2      = 11'h300;    // channel_summary_regs, channels 9..15
    localparam logic [10:0] A_SUMM3      = 11'h380;    // channel_summary_regs, channel 0
    localparam logic [10:0] A_TMST       = 11'h3c0;    // timer_irq_status_reg
    // Per-channel register bases
    localparam logic [10:0] A_CHCR       = 11'h000;    // channel_config_reg
    localparam logic [10:0] A_STATA      = 11'h200;    // Live status, first group
    localparam logic [10:0] A_STATB      = 11'h240;    // live_status_reg_b
    localparam logic [10:0] A_IES        = 11'h280;    // irq_edge_sel_reg
    localparam logic [10:0] A_FLAGA      = 11'h400;    // irq_status_reg_a
    localparam logic [10:0] A_FLAGB      = 11'h440;    // irq_status_reg_b
    localparam logic [10:0] A_FLAGC      = 11'h480;    // irq_status_reg_c
    localparam logic [10:0] A_MASKA      = 11'h500;    // irq_mask_reg_a
    localparam logic [10:0] A_MASKB      = 11'h540;    // irq_mask_reg_b
    localparam logic [10:0] A_MASKC      = 11'h580;    // irq_mask_reg_c
    localparam logic [10:0] A_BASE_MSK   = 11'h7e0;    // Register base part
    localparam logic [4:0]  CH0_CODE     = 5'h10;      // Channel code of channel 0
    // Field positions
    localparam int          GCR_TICK_IM  = 0;          // second_tick_mask
    localparam int          GCR_ALL_IM   = 1;          // global_irq_mask
    localparam int          CHCR_T1E1    = 0;          // Line mode bit
    localparam int          CHCR_SRST    = 1;          // channel_soft_reset
    localparam int          SUMM3_CH0    = 7;          // Channel 0 summary position
    // Used bit sets
    localparam logic [7:0]  LIVE_A_USED  = 8'h1f;      // Live sources in first group
    localparam logic [7:0]  LIVE_B_USED  = 8'he3;      // Live sources in second group
    localparam logic [7:0]  EVT_A_USED   = 8'he0;      // Direct events, first status register
    localparam logic [7:0]  EVT_C_USED   = 8'h3f;      // Direct events, third status register
    localparam logic [7:0]  IES_USED     = 8'h7f;      // Implemented edge selects
    localparam logic [4:0]  GCR_USED     = 5'h1f;      // Implemented config bits
    // Reset values
    localparam logic [7:0]  MSK_RST      = 8'hff;      // All sources masked
    localparam logic [4:0]  GCR_RST      = 5'h03;      // Global and timer masks set

    // Complete block state
    typedef struct packed {
        logic [NCH-1:0][7:0] live_a;    // Previous live status, first group
        logic [NCH-1:0][7:0] live_b;    // Previous live status, second group
        logic [NCH-1:0][7:0] ints_a;    // Latched flags a
        logic [NCH-1:0][7:0] ints_b;    // Latched flags b
        logic [NCH-1:0][7:0] ints_c;    // Latched flags c
        logic [NCH-1:0][7:0] msk_a;     // Masks a
        logic [NCH-1:0][7:0] msk_b;     // Masks b
        logic [NCH-1:0][7:0] msk_c;     // Masks c
        logic [NCH-1:0][7:0] ies;       // Edge selects
        logic [NCH-1:0]      t1e1;      // Line mode per channel
        logic [NCH-1:0][4:0] crst_cnt;  // Channel reset countdown
        logic [4:0]          grst_cnt;  // Global soft reset countdown
        logic [4:0]          gcr;       // Global configuration
        logic                tick_flag; // second_tick_flag
        logic [24:0]         sec_cnt;   // One-second counter
        logic [7:0]          rdata;     // Read data
        logic [NCH-1:0]      summ;      // channel_irq_summary
        logic                irq;       // Interrupt active
    } lia_state_type;

    localparam lia_state_type LIA_STATE_RST = '{
        msk_a: {NCH{MSK_RST}},
        msk_b: {NCH{MSK_RST}},
        msk_c: {NCH{MSK_RST}},
        gcr:   GCR_RST,
        default: '0
    };
endpackage

// >>> dv/lia_host_model.sv
// Purpose: Host processor on the register bus and the interrupt pin
// Assumes: Pin has a pull-up; reads answer one cycle later
// Notes:   Tasks are called from tb
`timescale 1ns/1ps
module lia_host_model
    import lia_pkg::*;
(
    input  wire logic          i_clk,      // Device clock
    input  wire logic [DW-1:0] i_rdata,    // Read data
    input  wire logic          i_irq_out,  // Pin drive value
    input  wire logic          i_irq_oe,   // Pin drive enable
    output logic      [AW-1:0] o_addr,     // Address
    output logic      [DW-1:0] o_wdata,    // Write data
    output logic               o_wr,       // Write strobe
    output logic               o_rd,       // Read strobe
    output logic               o_int_n     // Pin level seen by host
);
    initial begin
        o_addr = '0;
        o_wdata = '0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Pull-up holds the pin high when undriven
    assign o_int_n = i_irq_oe ? i_irq_out : 1'b1;
    // One-cycle write; ones acknowledge flags
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask
    // One-cycle read; data taken in the following cycle
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask
endmodule

// >>> dv/lia_irq_aggr_props.sv
// Purpose: Concurrent checks on the interrupt aggregator ports
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound from tb; channel 1 carries the channel reset start, read and mode checks
`timescale 1ns/1ps
module lia_irq_aggr_props
    import lia_pkg::*;
#(
    parameter logic [24:0] SEC_CYCLES = SEC_CYC  // Cycles per second tick
) (
    input wire logic                i_clk,
    input wire logic                i_srst,
    input wire logic [AW-1:0]       i_addr,
    input wire logic [DW-1:0]       i_wdata,
    input wire logic                i_wr,
    input wire logic                i_rd,
    input wire logic [DW-1:0]       o_rdata,
    input wire logic [NCH-1:0][7:0] i_live_a,
    input wire logic [NCH-1:0][7:0] i_live_b,
    input wire logic [NCH-1:0][7:0] i_evt_a,
    input wire logic [NCH-1:0][7:0] i_evt_c,
    input wire logic                i_jm_auto,
    input wire logic                o_irq_out,
    input wire logic                o_irq_oe,
    input wire logic [NCH-1:0]      o_chan_rst,
    input wire logic                o_glb_rst,
    input wire logic [NCH-1:0]      o_t1e1
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    localparam logic [10:0] CF1 = A_CHCR + 11'h001;  // Channel 1 config
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its slot");
    a_pin_low: assert property (o_irq_out == 1'b0)
        else $error("pin drive value not low");
    a_reset_quiet: assert property ($fell(i_srst) |-> !o_irq_oe && o_rdata == 8'h00)
        else $error("outputs active after reset");
    a_channel_soft_reset_start: assert property (i_wr && i_addr == CF1 && i_wdata[1] && !o_glb_rst |=> o_chan_rst[1])
        else $error("channel reset did not start");
    a_channel_soft_reset_read: assert property (i_rd && i_addr == CF1 && o_chan_rst[1] |=> o_rdata[1])
        else $error("running channel reset reads zero");
    a_mode_kept: assert property (o_chan_rst[1] && !i_wr |=> $stable(o_t1e1))
        else $error("mode bit changed by channel reset");
    a_glb_rst_len: assert property (i_wr && i_addr == A_GRST && !o_glb_rst
        |=> o_glb_rst ##24 o_glb_rst ##1 !o_glb_rst)
        else $error("global soft reset length wrong");
    a_glb_rst_quiet: assert property (o_glb_rst |=> !o_irq_oe)
        else $error("pin active during global reset");
    a_irq_release: assert property ($fell(o_irq_oe) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3)
        || $past(o_glb_rst) || $past(|o_chan_rst))
        else $error("pin released without acknowledge");
    // Every channel reset ends within the limit
    for (genvar k = 0; k < NCH; k++) begin : g_ch
        a_channel_soft_reset_bounded: assert property ($rose(o_chan_rst[k]) |-> ##[1:25] !o_chan_rst[k])
            else $error("channel reset too long");
    end
endmodule

// >>> dv/tb.sv
// Purpose: Self-checking bench for the interrupt aggregator
// Assumes: Host model speaks the register bus
// Notes:   Second tick shortened to 50 cycles; events on channel 1
`timescale 1ns/1ps
module tb;
    import lia_pkg::*;
    localparam logic [24:0] SEC_T = 25'd50;  // Short tick
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata;
    logic wr, rd, jm_auto = 1'b0, irq_out, irq_oe, glb_rst, int_n;
    logic [NCH-1:0][7:0] live_a = '0, live_b = '0, evt_a = '0, evt_c = '0;
    logic [NCH-1:0] chan_rst, t1e1;
    logic [7:0] d;
    int fail_count = 0;
    int check_count = 0;
    int eb[5] = '{5, 5, 1, 0, 0};  // Live bit under test
    logic [7:0] ei[5] = '{8'h00, 8'h20, 8'h01, 8'h00, 8'h01};  // Edge select value
    bit evc[4] = '{0, 0, 1, 1};  // Direct source in third group
    int evb[4] = '{5, 6, 0, 1};  // Direct source bit
    always #20 clk = ~clk;
    lia_irq_aggr #(.SEC_CYCLES(SEC_T)) lia_irq_aggr_i (.i_clk(clk), .i_srst(srst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_live_a(live_a), .i_live_b(live_b),
        .i_evt_a(evt_a), .i_evt_c(evt_c), .i_jm_auto(jm_auto), .o_irq_out(irq_out), .o_irq_oe(irq_oe),
        .o_chan_rst(chan_rst), .o_glb_rst(glb_rst), .o_t1e1(t1e1));
    lia_host_model lia_host_model_i (.i_clk(clk), .i_rdata(rdata), .i_irq_out(irq_out), .i_irq_oe(irq_oe),
        .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_int_n(int_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [10:0] a, input logic [7:0] exp);
        lia_host_model_i.rd(a, d);
        chk(d, exp);
    endtask
    task automatic wr1(input logic [10:0] a, input logic [7:0] v);
        lia_host_model_i.wr(a, v);
    endtask
    // Pin level after the flag-to-pin delay
    task automatic pin(input logic exp);
        repeat (4) @(posedge clk);
        #1 chk({7'h00, int_n}, {7'h00, exp});
    endtask
    // One-cycle event pulse on channel 1
    task automatic pulse(input bit c, input int b);
        @(posedge clk);
        if (c) evt_c[1][b] <= 1'b1;
        else evt_a[1][b] <= 1'b1;
        @(posedge clk);
        evt_c[1] <= 8'h00;
        evt_a[1] <= 8'h00;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done;
    end
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rc(A_GCR, 8'h03);
        rc(A_MASKA + 11'h001, 8'hff);
        rc(A_MASKC + 11'h001, 8'hff);
        rc(11'h600, 8'h00);
        wr1(A_GCR, 8'h00);
        wr1(A_MASKA + 11'h001, 8'h00);
        wr1(A_MASKB + 11'h001, 8'h00);
        wr1(A_MASKC + 11'h001, 8'h00);
        // Direct sources latch, raise pin and summary, clear on one
        for (int i = 0; i < 4; i++) begin
            logic [10:0] sa;
            sa = evc[i] ? A_FLAGC + 11'h001 : A_FLAGA + 11'h001;
            pulse(evc[i], evb[i]);
            pin(1'b0);
            rc(A_SUMM1, 8'h01);
            rc(sa, 8'h01 << evb[i]);
            wr1(sa, 8'h00);
            rc(sa, 8'h01 << evb[i]);
            wr1(sa, 8'h01 << evb[i]);
            pin(1'b1);
            rc(A_SUMM1, 8'h00);
        end
        // Summary holds until both flags acknowledged
        pulse(1'b1, 0);
        pulse(1'b1, 1);
        wr1(A_FLAGC + 11'h001, 8'h01);
        pin(1'b0);
        rc(A_SUMM1, 8'h01);
        wr1(A_FLAGC + 11'h001, 8'h02);
        pin(1'b1);
        // Individual then global mask
        wr1(A_MASKC + 11'h001, 8'h02);
        pulse(1'b1, 1);
        pin(1'b1);
        rc(A_FLAGC + 11'h001, 8'h02);
        rc(A_SUMM1, 8'h00);
        wr1(A_MASKC + 11'h001, 8'h00);
        pin(1'b0);
        wr1(A_GCR, 8'h02);
        pin(1'b1);
        wr1(A_GCR, 8'h00);
        wr1(A_FLAGC + 11'h001, 8'h02);
        // Edge select on live sources
        for (int i = 0; i < 5; i++) begin
            wr1(A_IES + 11'h001, ei[i]);
            live_b[1][eb[i]] <= 1'b1;
            rc(A_FLAGB + 11'h001, 8'h01 << eb[i]);
            wr1(A_FLAGB + 11'h001, 8'h01 << eb[i]);
            live_b[1][eb[i]] <= 1'b0;
            repeat (3) @(posedge clk);
            rc(A_FLAGB + 11'h001, (ei[i] != 8'h00) ? 8'h01 << eb[i] : 8'h00);
            wr1(A_FLAGB + 11'h001, 8'hff);
        end
        // First group: line loss follows the shared loss select
        live_a[1][0] <= 1'b1;
        repeat (2) @(posedge clk);
        rc(A_FLAGA + 11'h001, 8'h01);
        wr1(A_IES + 11'h001, 8'h02);
        wr1(A_FLAGA + 11'h001, 8'h01);
        live_a[1][0] <= 1'b0;
        repeat (3) @(posedge clk);
        rc(A_FLAGA + 11'h001, 8'h01);
        wr1(A_FLAGA + 11'h001, 8'hff);
        // One-second tick
        jm_auto <= 1'b1;
        repeat (55) @(posedge clk);
        jm_auto <= 1'b0;
        rc(A_TMST, 8'h01);
        pin(1'b0);
        wr1(A_GCR, 8'h01);
        pin(1'b1);
        wr1(A_GCR, 8'h00);
        wr1(A_TMST, 8'h01);
        rc(A_TMST, 8'h00);
        pin(1'b1);
        // Channel reset on channel 1 only
        wr1(A_MASKC + 11'h002, 8'h00);
        wr1(A_CHCR + 11'h001, 8'h01);
        pulse(1'b1, 1);
        wr1(A_CHCR + 11'h001, 8'h03);
        rc(A_CHCR + 11'h001, 8'h03);
        repeat (30) @(posedge clk);
        rc(A_CHCR + 11'h001, 8'h01);
        rc(A_MASKC + 11'h001, 8'hff);
        rc(A_FLAGC + 11'h001, 8'h00);
        rc(A_MASKC + 11'h002, 8'h00);
        rc(A_GCR, 8'h00);
        pin(1'b1);
        // Global soft reset masks everything
        wr1(A_GRST, 8'h00);
        repeat (30) @(posedge clk);
        rc(A_GCR, 8'h03);
        rc(A_MASKC + 11'h002, 8'hff);
        test_done;
    end
endmodule
bind lia_irq_aggr lia_irq_aggr_props #(.SEC_CYCLES(SEC_CYCLES)) lia_irq_aggr_props_i (.i_clk(i_clk),
    .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_live_a(i_live_a), .i_live_b(i_live_b), .i_evt_a(i_evt_a), .i_evt_c(i_evt_c), .i_jm_auto(i_jm_auto),
    .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe), .o_chan_rst(o_chan_rst), .o_glb_rst(o_glb_rst), .o_t1e1(o_t1e1));

// >>> rtl/lia_irq_aggr.sv
// Purpose: Interrupt aggregation for a sixteen channel line interface
// Assumes: Detectors run on i_clk; events are one-cycle pulses
// Notes:   Mask bit 1 means masked; interrupt pin is active-low open drain
//
// Behaviour
// [RL1] Nineteen sources per channel, one global
// [RL2] Live-status sources latch on selected edges
// [RL3] Direct sources latch flag on event
// [RL4] Global mask plus per-source masks
// [RL5] Unmasked event asserts interrupt pin
// [RL6] Unmasked channel event sets channel summary
// [RL7] Host clears flag by writing one
// [RL8] Summary holds until channel fully acknowledged
// [RL9] Pin releases after every flag acknowledged
// [RL10] Pattern sync source at bit five
// [RL11] Loop codes share edge bit zero
// [RL12] Jitter buffer faults at bits five, six
// [RL13] Pattern error at third register bit one
// [RL14] Error counter wrap at third bit zero
// [RL15] Second tick flag, config bit zero mask
// [RL16] Full reset masks every source
// [RL17] Channel reset masks only that channel
// [RL18] Channel reset bit self-clears within microsecond
// [RL19] Channel reset leaves global registers alone
// [RL20] Second tick fires under automatic timing
// [RL21] Pin is masked OR, active-low
`timescale 1ns/1ps
module lia_irq_aggr
    import lia_pkg::*;
#(
    parameter logic [24:0] SEC_CYCLES = SEC_CYC      // Cycles per second tick
) (
    input  wire logic                i_clk,          // Device clock
    input  wire logic                i_srst,         // Synchronous reset
    input  wire logic [AW-1:0]       i_addr,         // Register address
    input  wire logic [DW-1:0]       i_wdata,        // Write data
    input  wire logic                i_wr,           // Write strobe
    input  wire logic                i_rd,           // Read strobe
    output logic      [DW-1:0]       o_rdata,        // Read data, one cycle later
    input  wire logic [NCH-1:0][7:0] i_live_a,       // Live status, first group
    input  wire logic [NCH-1:0][7:0] i_live_b,       // Live status, second group
    input  wire logic [NCH-1:0][7:0] i_evt_a,        // Event pulses, first flags
    input  wire logic [NCH-1:0][7:0] i_evt_c,        // Event pulses, third flags
    input  wire logic                i_jm_auto,      // Automatic one-second timing
    output logic                     o_irq_out,      // Pin drive value, always low
    output logic                     o_irq_oe,       // Pin pulled low when high
    output logic      [NCH-1:0]      o_chan_rst,     // Channel reset in progress
    output logic                     o_glb_rst,      // Global soft reset in progress
    output logic      [NCH-1:0]      o_t1e1          // Line mode per channel
);

    lia_state_type s_r;                              // Registered state
    lia_state_type s_nxt;                            // Next state

    // Edge select bit for a first-group status bit
    function automatic int ies_pos_a(input int k);
        case (k)
            0:       ies_pos_a = 1;                  // Line loss shares with system loss
            default: ies_pos_a = k;
        endcase
    endfunction

    // Edge select bit for a second-group status bit
    function automatic int ies_pos_b(input int k);
        case (k)
            1:       ies_pos_b = 0;                  // Loop-up code shares bit zero
            7:       ies_pos_b = 6;                  // Both alarm sources share bit six
            default: ies_pos_b = k;
        endcase
    endfunction

    // Channel field of an address: returns valid flag and index
    function automatic logic [5:0] chan_dec(input logic [4:0] code);
        if (code == CH0_CODE) begin
            chan_dec = 6'h20;
        end else if (code[4] == 1'b0 && code != 5'h00) begin
            chan_dec = {2'b10, code[3:0]};
        end else begin
            chan_dec = 6'h00;
        end
    endfunction

    // Next-state logic
    always_comb begin
        logic [5:0]  cd;
        logic        cv;
        logic [3:0]  ch;
        logic [10:0] base;
        logic        glb;
        logic        wr_c;
        logic [7:0]  cur_a;
        logic [7:0]  cur_b;
        logic [7:0]  chg_a;
        logic [7:0]  chg_b;
        logic [7:0]  es_a;
        logic [7:0]  es_b;
        logic [7:0]  set_a;
        logic [7:0]  set_b;
        logic [7:0]  set_c;
        logic [7:0]  clr_a;
        logic [7:0]  clr_b;
        logic [7:0]  clr_c;
        logic        any;
        cd    = chan_dec(i_addr[4:0]);
        cv    = cd[5];
        ch    = cd[3:0];
        base  = i_addr & A_BASE_MSK;
        glb   = (i_addr[4:0] == 5'h00);
        wr_c  = 1'b0;
        cur_a = '0;
        cur_b = '0;
        chg_a = '0;
        chg_b = '0;
        es_a  = '0;
        es_b  = '0;
        set_a = '0;
        set_b = '0;
        set_c = '0;
        clr_a = '0;
        clr_b = '0;
        clr_c = '0;
        any   = 1'b0;
        s_nxt = s_r;

        // Global timer: counts only in automatic measurement timing
        if (i_jm_auto) begin
            if (s_r.sec_cnt >= SEC_CYCLES - 25'd1) begin
                s_nxt.sec_cnt   = '0;
                s_nxt.tick_flag = 1'b1;              // RL20
            end else begin
                s_nxt.sec_cnt = s_r.sec_cnt + 25'd1;
            end
        end else begin
            s_nxt.sec_cnt = '0;
        end

        // Timer flag clear by writing one; tick wins
        if (i_wr && i_addr == A_TMST && i_wdata[0] && !(i_jm_auto && s_r.sec_cnt >= SEC_CYCLES - 25'd1)) begin
            s_nxt.tick_flag = 1'b0;                  // RL15 RL7
        end

        // Global config writes
        if (i_wr && i_addr == A_GCR) begin
            s_nxt.gcr = i_wdata[4:0] & GCR_USED;     // RL4 RL15
        end

        // Global soft reset start
        if (i_wr && i_addr == A_GRST) begin
            s_nxt.grst_cnt = RST_CYC;
        end

        // Per-channel processing
        for (int c = 0; c < NCH; c++) begin
            wr_c  = i_wr && cv && (ch == 4'(c));
            cur_a = i_live_a[c] & LIVE_A_USED;
            cur_b = i_live_b[c] & LIVE_B_USED;
            chg_a = cur_a ^ s_r.live_a[c];
            chg_b = cur_b ^ s_r.live_b[c];
            for (int k = 0; k < 8; k++) begin
                es_a[k] = s_r.ies[c][ies_pos_a(k)];
                es_b[k] = s_r.ies[c][ies_pos_b(k)];  // RL10 RL11
            end
            // Rising edge always; falling edge when selected
            set_a = (cur_a & ~s_r.live_a[c]) | (chg_a & es_a);       // RL2
            set_b = (cur_b & ~s_r.live_b[c]) | (chg_b & es_b);       // RL2
            set_a = set_a | (i_evt_a[c] & EVT_A_USED);              // RL3 RL12
            set_c = i_evt_c[c] & EVT_C_USED;                         // RL3 RL13 RL14
            clr_a = (wr_c && base == A_FLAGA) ? i_wdata : 8'h00;
            clr_b = (wr_c && base == A_FLAGB) ? i_wdata : 8'h00;
            clr_c = (wr_c && base == A_FLAGC) ? i_wdata : 8'h00;
            // Write-one clears, a same-cycle event wins
            s_nxt.ints_a[c] = (s_r.ints_a[c] & ~clr_a) | set_a;     // RL7
            s_nxt.ints_b[c] = (s_r.ints_b[c] & ~clr_b) | (set_b & LIVE_B_USED);
            s_nxt.ints_c[c] = (s_r.ints_c[c] & ~clr_c) | set_c;
            s_nxt.live_a[c] = cur_a;
            s_nxt.live_b[c] = cur_b;
            // Mask and edge select writes
            if (wr_c && base == A_MASKA) begin
                s_nxt.msk_a[c] = i_wdata;                            // RL4
            end
            if (wr_c && base == A_MASKB) begin
                s_nxt.msk_b[c] = i_wdata;
            end
            if (wr_c && base == A_MASKC) begin
                s_nxt.msk_c[c] = i_wdata;
            end
            if (wr_c && base == A_IES) begin
                s_nxt.ies[c] = i_wdata & IES_USED;
            end
            // Channel config: mode bit and reset start
            if (wr_c && base == A_CHCR) begin
                s_nxt.t1e1[c] = i_wdata[CHCR_T1E1];
                if (i_wdata[CHCR_SRST]) begin
                    s_nxt.crst_cnt[c] = RST_CYC;                     // RL18
                end
            end
            // Channel reset: only this channel, mode and globals untouched
            if (s_r.crst_cnt[c] != 5'd0) begin
                s_nxt.crst_cnt[c] = 5'(s_r.crst_cnt[c] - 5'd1);     // RL18 RL19
                s_nxt.ints_a[c]   = '0;
                s_nxt.ints_b[c]   = '0;
                s_nxt.ints_c[c]   = '0;
                s_nxt.msk_a[c]    = MSK_RST;                         // RL17
                s_nxt.msk_b[c]    = MSK_RST;                         // RL17
                s_nxt.msk_c[c]    = MSK_RST;                         // RL17
                s_nxt.ies[c]      = '0;
            end
            // Summary: any unmasked pending flag of the channel
            s_nxt.summ[c] = |((s_r.ints_a[c] & ~s_r.msk_a[c])
                            | (s_r.ints_b[c] & ~s_r.msk_b[c])
                            | (s_r.ints_c[c] & ~s_r.msk_c[c]));      // RL6 RL8
            any = any | s_nxt.summ[c];                               // RL1
        end

        // Pin: OR of all unmasked flags, then global mask
        any = any | (s_r.tick_flag & ~s_r.gcr[GCR_TICK_IM]);        // RL15
        s_nxt.irq = any & ~s_r.gcr[GCR_ALL_IM];                      // RL21 RL4 RL5 RL9

        // Read mux
        s_nxt.rdata = '0;
        if (i_rd) begin
            if (glb) begin
                case (i_addr)
                    A_GCR:   s_nxt.rdata = {3'b000, s_r.gcr};
                    A_SUMM1: s_nxt.rdata = s_r.summ[8:1];
                    A_SUMM2: s_nxt.rdata = {1'b0, s_r.summ[15:9]};
                    A_SUMM3: s_nxt.rdata = {s_r.summ[0], 7'h00};
                    A_TMST:  s_nxt.rdata = {7'h00, s_r.tick_flag};
                    default: s_nxt.rdata = '0;
                endcase
            end else if (cv) begin
                case (base)
                    A_CHCR:  s_nxt.rdata = {6'h00, (s_r.crst_cnt[ch] != 5'd0), s_r.t1e1[ch]};
                    A_STATA: s_nxt.rdata = s_r.live_a[ch];
                    A_STATB: s_nxt.rdata = s_r.live_b[ch];
                    A_IES:   s_nxt.rdata = s_r.ies[ch];
                    A_FLAGA: s_nxt.rdata = s_r.ints_a[ch];
                    A_FLAGB: s_nxt.rdata = s_r.ints_b[ch];
                    A_FLAGC: s_nxt.rdata = s_r.ints_c[ch];
                    A_MASKA: s_nxt.rdata = s_r.msk_a[ch];
                    A_MASKB: s_nxt.rdata = s_r.msk_b[ch];
                    A_MASKC: s_nxt.rdata = s_r.msk_c[ch];
                    default: s_nxt.rdata = '0;
                endcase
            end else begin
                s_nxt.rdata = '0;                    // Unmapped
            end
        end

        // Global soft reset: everything to defaults while counting
        if (s_r.grst_cnt != 5'd0) begin
            s_nxt          = LIA_STATE_RST;          // RL16
            s_nxt.grst_cnt = 5'(s_r.grst_cnt - 5'd1);
        end
    end

    // State register; channel reset never reaches global fields
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_r <= LIA_STATE_RST;                    // RL16
        end else begin
            s_r <= s_nxt;                            // RL19
        end
    end

    // Outputs
    assign o_rdata    = s_r.rdata;
    assign o_irq_out  = 1'b0;                        // Open drain only ever pulls low
    assign o_irq_oe   = s_r.irq;                     // RL21
    assign o_glb_rst  = (s_r.grst_cnt != 5'd0);
    assign o_t1e1     = s_r.t1e1;
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            o_chan_rst[c] = (s_r.crst_cnt[c] != 5'd0);
        end
    end

endmodule
